// ===== hdl/cape_handler.sv
`timescale 1ns/1ps
// Overview of operation
// - parity failure sets sticky status bit in the same cycle as the alert
// - alert driven low soon after failure
// - failing command and address bits logged
// - write crc status cleared on parity failure
// - in-flight commands reaching drain allowed to finish
// - wait row active minimum, precharge all
// - commands execute in alert window only in its first cycle and the drain part
// - release alert after min width, precharged
// - checking suspended until status cleared
// - log kept until next detected failure; status clear leaves it
// - latency write-only, status rw, log read-only
// - persistent mode resumes checking after alert
// - three-bit latency code, nonzero enables
// - latency delays every command
// - failed self refresh entry becomes power-down
// - even parity over covered inputs
// - cover command and address, not control
// - command held latency cycles before execution
// - failing command never executed
`include "cape_params.svh"
module cape_handler
    import cape_pkg::*;
#(
    parameter int CMD_W = `CAPE_CMD_W,
    parameter int MAX_PL = 8
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // command bus pins
    input wire logic cmd_valid_pin,
    input wire logic [CMD_W-1:0] cmd_bits_pin,
    input wire logic cmd_parity_bit,
    input wire logic cmd_is_sre_pin,
    // mode register write port and crc error event
    input wire logic mr5_wr,
    input wire logic [15:0] mr5_wdata,
    input wire logic crc_error_evt,
    // executed command stream
    output logic exec_valid,
    output logic [CMD_W-1:0] exec_bits,
    output logic enter_pd,
    output logic prech_all,
    // status and pins
    output logic alert_n,
    output logic parity_err_status,
    output logic crc_err_status,
    output logic [CMD_W-1:0] err_log,
    output logic [15:0] mr5_rdata
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [CMD_W+2:0] s1_q;
    logic [CMD_W+2:0] s2_q; // only s2_q is read by logic
    always_ff @(posedge mclk)
    begin
        s1_q <= {cmd_valid_pin, cmd_is_sre_pin, cmd_parity_bit, cmd_bits_pin};
        s2_q <= s1_q;
    end
    logic v_in;
    logic sre_in;
    logic [CMD_W-1:0] bits_in;
    logic par_in;
    assign v_in = s2_q[CMD_W+2];
    assign sre_in = s2_q[CMD_W+1];
    assign par_in = s2_q[CMD_W];
    assign bits_in = s2_q[CMD_W-1:0];
    // ----------------------------------------
    // mode register fields
    // ----------------------------------------
    logic [2:0] pl_q; // write-only latency code
    logic persist_q;
    cape_state_t st_q;
    logic chk_en_q; // checking active (cleared while suspended)
    logic [7:0] cnt_q;
    logic perr;
    logic [3:0] pl_cyc;
    // latency code to cycles, reserved codes treated as eight
    always_comb
    begin
        case (pl_q)
            `CAPE_PL_OFF: pl_cyc = 4'h0;
            `CAPE_PL_4: pl_cyc = 4'h4;
            `CAPE_PL_5: pl_cyc = 4'h5;
            `CAPE_PL_6: pl_cyc = 4'h6;
            default: pl_cyc = 4'h8;
        endcase
    end
    // latency register, direct nonzero change is left to the controller
    always_ff @(posedge mclk)
    begin
        if (srst)
            pl_q <= `CAPE_PL_OFF;
        else if (mr5_wr)
            pl_q <= mr5_wdata[`CAPE_MR5_PL_LSB +: 3];
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
            persist_q <= 1'b0;
        else if (mr5_wr)
            persist_q <= mr5_wdata[`CAPE_MR5_PERSIST_BIT];
    end
    // ----------------------------------------
    // parity check
    // ----------------------------------------
    // even parity across covered bits; control pins are not on bits_in
    assign perr = v_in && (pl_q != `CAPE_PL_OFF) && chk_en_q
        && (^{bits_in, par_in});
    // ----------------------------------------
    // latency delay line
    // ----------------------------------------
    logic [CMD_W+1:0] dl_q [MAX_PL:0];
    logic blocked;
    assign blocked = (st_q == CAPE_FLAG_DLY) || (st_q == CAPE_PRECH) || (st_q == CAPE_HOLD);
    assign dl_q[0] = {v_in && !perr, sre_in, bits_in};
    genvar gi;
    generate
        for (gi = 1; gi <= MAX_PL; gi++)
        begin : g_dl
            always_ff @(posedge mclk)
            begin
                if (srst)
                    dl_q[gi] <= '0;
                else
                    dl_q[gi] <= dl_q[gi-1];
            end
        end
    endgenerate
    logic [CMD_W+1:0] tap;
    // pick the tap for the programmed latency
    always_comb
    begin
        tap = dl_q[pl_cyc];
    end
    // executed stream; drain lets earlier commands out
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            exec_valid <= 1'b0;
            exec_bits <= '0;
            enter_pd <= 1'b0;
        end
        else
        begin
            exec_valid <= tap[CMD_W+1] && !blocked;
            exec_bits <= tap[CMD_W-1:0];
            // failed self refresh entry is masked and becomes power-down
            enter_pd <= perr && sre_in;
        end
    end
    // ----------------------------------------
    // recovery sequencer
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q <= CAPE_IDLE;
            cnt_q <= 8'h00;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            case (st_q)
                CAPE_IDLE:
                    if (perr)
                    begin
                        st_q <= CAPE_FLAG_DLY;
                        cnt_q <= 8'h00;
                    end
                CAPE_FLAG_DLY: // execution blocked while alert goes out
                    if (cnt_q >= 8'(`CAPE_ASSERT_DLY_CYC - 1))
                    begin
                        st_q <= CAPE_DRAIN;
                        cnt_q <= 8'h00;
                    end
                CAPE_DRAIN: // honour row active minimum
                    if (cnt_q >= 8'(`CAPE_RAS_MIN_CYC - 1))
                        st_q <= CAPE_PRECH;
                CAPE_PRECH:
                    st_q <= CAPE_HOLD;
                CAPE_HOLD: // release once min width met and precharged
                    if (cnt_q >= 8'(`CAPE_PW_MIN_CYC - 1))
                        st_q <= CAPE_IDLE;
                default:
                    st_q <= CAPE_IDLE;
            endcase
        end
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            alert_n <= 1'b1;
            prech_all <= 1'b0;
        end
        else
        begin
            alert_n <= !((perr && st_q == CAPE_IDLE) || (st_q != CAPE_IDLE
                && !(st_q == CAPE_HOLD && cnt_q >= 8'(`CAPE_PW_MIN_CYC - 1))));
            prech_all <= (st_q == CAPE_DRAIN) && (cnt_q >= 8'(`CAPE_RAS_MIN_CYC - 1));
        end
    end
    // ----------------------------------------
    // status, checking enable, log
    // ----------------------------------------
    // status set wins over a zero write; writes of one are blocked
    always_ff @(posedge mclk)
    begin
        if (srst)
            parity_err_status <= 1'b0;
        else if (perr)
            parity_err_status <= 1'b1;
        else if (mr5_wr && !mr5_wdata[`CAPE_MR5_ERR_BIT])
            parity_err_status <= 1'b0;
    end
    // checking back on at clear, or at alert release in persistent mode
    always_ff @(posedge mclk)
    begin
        if (srst)
            chk_en_q <= 1'b1;
        else if (perr)
            chk_en_q <= 1'b0;
        else if (persist_q && st_q == CAPE_HOLD && cnt_q >= 8'(`CAPE_PW_MIN_CYC - 1))
            chk_en_q <= 1'b1;
        else if (mr5_wr && !mr5_wdata[`CAPE_MR5_ERR_BIT])
            chk_en_q <= 1'b1;
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
            crc_err_status <= 1'b0;
        else if (perr)
            crc_err_status <= 1'b0;
        else if (crc_error_evt)
            crc_err_status <= 1'b1;
        else if (mr5_wr && !mr5_wdata[`CAPE_MR5_CRC_BIT])
            crc_err_status <= 1'b0;
    end
    // later failures overwrite; in persistent mode contents may be stale
    always_ff @(posedge mclk)
    begin
        if (srst)
            err_log <= '0;
        else if (perr)
            err_log <= bits_in;
    end
    // latency reads as zero since it is write-only
    always_ff @(posedge mclk)
    begin
        if (srst)
            mr5_rdata <= 16'h0000;
        else
        begin
            mr5_rdata <= 16'h0000;
            mr5_rdata[`CAPE_MR5_CRC_BIT] <= crc_err_status;
            mr5_rdata[`CAPE_MR5_ERR_BIT] <= parity_err_status;
            mr5_rdata[`CAPE_MR5_PERSIST_BIT] <= persist_q;
        end
    end
endmodule : cape_handler

// ===== inc/cape_params.svh
`ifndef CAPE_PARAMS_SVH
`define CAPE_PARAMS_SVH
// ----------------------------------------
// parity latency codes
// ----------------------------------------
`define CAPE_PL_OFF 3'h0
`define CAPE_PL_4 3'h1
`define CAPE_PL_5 3'h2
`define CAPE_PL_6 3'h3
`define CAPE_PL_8 3'h4
// ----------------------------------------
// mode_reg_five field positions
// ----------------------------------------
`define CAPE_MR5_PL_LSB 0
`define CAPE_MR5_CRC_BIT 3
`define CAPE_MR5_ERR_BIT 4
`define CAPE_MR5_PERSIST_BIT 9
// ----------------------------------------
// timing, clock cycles at 25 MHz
// ----------------------------------------
`define CAPE_CLK_NS 40
`define CAPE_ASSERT_DLY_CYC 2
`define CAPE_PW_MIN_CYC 8
`define CAPE_PW_MAX_CYC 16
`define CAPE_RAS_MIN_CYC 4
`define CAPE_CMD_W 25
`endif

// ===== inc/cape_pkg.sv
package cape_pkg;
    // recovery sequencer states
    typedef enum logic [2:0] {CAPE_IDLE, CAPE_FLAG_DLY, CAPE_DRAIN, CAPE_PRECH, CAPE_HOLD}
        cape_state_t;
endpackage : cape_pkg

// ===== verification/cape_ctrl_model.sv
`timescale 1ns/1ps
// ------------------------------------
// controller side of the command bus
// ------------------------------------
module cape_ctrl_model #(
    parameter int CMD_W = 25
)
(
    // clock and alert from the device
    input wire logic mclk,
    input wire logic alert_n,
    // command pins toward the device
    output logic cmd_valid_pin,
    output logic [CMD_W-1:0] cmd_bits_pin,
    output logic cmd_parity_bit,
    output logic cmd_is_sre_pin
);
    initial
    begin
        cmd_valid_pin = 1'b0;
        cmd_bits_pin = '0;
        cmd_parity_bit = 1'b0;
        cmd_is_sre_pin = 1'b0;
    end
    // one command for one cycle; bad flips the parity on purpose
    task automatic send(input logic [CMD_W-1:0] b, input logic bad, input logic self_refresh_entry);
        // only deselects while the alert is low
        while (alert_n !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        cmd_valid_pin = 1'b1;
        cmd_bits_pin = b;
        cmd_parity_bit = (^b) ^ bad;
        cmd_is_sre_pin = self_refresh_entry;
        @(negedge mclk);
        // deselect: released lines show the inverse, not a stale copy
        cmd_valid_pin = 1'b0;
        cmd_bits_pin = ~b;
        cmd_parity_bit = ~cmd_parity_bit;
        cmd_is_sre_pin = 1'b0;
    endtask : send
endmodule : cape_ctrl_model

// ===== verification/cape_handler_bench.sv
`timescale 1ns/1ps
// ------------------------------------
// self-checking bench
// ------------------------------------
module cape_handler_bench;
    localparam int W = 25;
    localparam logic [W-1:0] BAD1 = 25'h0A5C3E1;
    localparam logic [W-1:0] BAD2 = 25'h1234567;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic mr5_wr = 1'b0;
    logic [15:0] mr5_wdata = 16'h0000;
    logic crc_error_evt = 1'b0;
    logic cmd_valid_pin, cmd_parity_bit, cmd_is_sre_pin;
    logic [W-1:0] cmd_bits_pin, exec_bits, err_log, watch;
    logic [15:0] mr5_rdata; // status readback
    logic exec_valid, enter_pd, prech_all, alert_n, parity_err_status, crc_err_status;
    logic pd_seen, pr_seen, hit; // monitor flags
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    // clock never stops, so an alert after a failed entry attempt is always seen
    always #20 mclk = ~mclk;
    cape_handler i_dut (.*);
    cape_ctrl_model i_ctl (.*);
    // flags and hang limit
    always @(posedge mclk)
    begin
        cyc++;
        if (enter_pd) pd_seen = 1'b1;
        if (prech_all) pr_seen = 1'b1;
        if (exec_valid && exec_bits === watch) hit = 1'b1;
        if (cyc == 3000)
        begin
            err_count++;
            final_report();
        end
    end
    task automatic cmp(input logic [W-1:0] got, input logic [W-1:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        if (got !== exp)
            err_count++;
    endtask : cmp
    task automatic cmpb(input logic g, input logic e);
        cmp(W'(g), W'(e));
    endtask : cmpb
    task automatic mode_wr(input logic [2:0] lat, input logic st, input logic per);
        @(negedge mclk);
        mr5_wdata = {6'h00, per, 4'h0, st, 1'b0, lat};
        mr5_wr = 1'b1;
        @(negedge mclk);
        mr5_wr = 1'b0;
        repeat (2) @(negedge mclk);
    endtask : mode_wr
    task automatic wait_al(input logic lvl);
        for (int n = 0; n < 40 && alert_n !== lvl; n++) @(negedge mclk);
        cmpb(alert_n, lvl);
    endtask : wait_al
    task automatic t_lat;
        int pc [6] = '{0, 4, 5, 6, 8, 8};
        int n;
        // last pass uses a reserved code, which the design runs as eight
        for (int c = 0; c < 6; c++)
        begin
            mode_wr(3'h0, 1'b0, 1'b0);
            mode_wr(3'(c), 1'b0, 1'b0);
            i_ctl.send(BAD2 + W'(c), 1'b0, 1'b0);
            for (n = 1; n < 20 && exec_valid !== 1'b1; n++) @(negedge mclk);
            cmp(W'(n), W'(pc[c] + 3));
            cmp(exec_bits, BAD2 + W'(c));
        end
        $display("latency test ended");
    endtask : t_lat
    task automatic t_err;
        mode_wr(3'h0, 1'b0, 1'b0);
        mode_wr(3'h1, 1'b0, 1'b0);
        cmp({parity_err_status, crc_err_status, alert_n}, 3'h1);
        crc_error_evt = 1'b1;
        @(negedge mclk);
        crc_error_evt = 1'b0;
        {pr_seen, hit, watch} = {2'h0, BAD1};
        i_ctl.send(BAD1, 1'b1, 1'b0);
        wait_al(1'b0);
        cmp({parity_err_status, crc_err_status}, 2'h2);
        cmp(err_log, BAD1);
        wait_al(1'b1);
        cmp(W'(mr5_rdata), 25'h0000010);
        cmp({pr_seen, hit}, 2'h2);
        {hit, watch} = {1'b0, BAD2};
        i_ctl.send(BAD2, 1'b1, 1'b0);
        repeat (12) @(negedge mclk);
        cmp({alert_n, hit}, 2'h3);
        cmp(err_log, BAD1);
        mode_wr(3'h1, 1'b1, 1'b0);
        cmpb(parity_err_status, 1'b1);
        mode_wr(3'h1, 1'b0, 1'b0);
        cmpb(parity_err_status, 1'b0);
        i_ctl.send(BAD2, 1'b1, 1'b0);
        wait_al(1'b0);
        cmp(err_log, BAD2);
        wait_al(1'b1);
        $display("error test ended");
    endtask : t_err
    task automatic t_per;
        mode_wr(3'h0, 1'b0, 1'b1);
        mode_wr(3'h2, 1'b0, 1'b1);
        i_ctl.send(BAD1, 1'b1, 1'b0);
        wait_al(1'b0);
        wait_al(1'b1);
        pd_seen = 1'b0;
        i_ctl.send(BAD2, 1'b1, 1'b1);
        wait_al(1'b0);
        cmpb(parity_err_status, 1'b1);
        wait_al(1'b1);
        cmpb(pd_seen, 1'b1);
        cmp(W'(mr5_rdata), 25'h0000210);
        // two failures before a clear leave the log undefined: not compared
        $display("persistent test ended");
    endtask : t_per
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial
    begin
        watch = '0;
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        @(negedge mclk);
        t_lat();
        t_err();
        t_per();
        final_report();
    end
endmodule : cape_handler_bench

// ===== verification/cape_handler_chk.sv
`timescale 1ns/1ps
// ------------------------------------
// port checker for the parity handler
// ------------------------------------
module cape_handler_chk #(
    parameter int CMD_W = 25
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // inputs
    input wire logic cmd_valid_pin,
    input wire logic [CMD_W-1:0] cmd_bits_pin,
    input wire logic cmd_parity_bit,
    input wire logic cmd_is_sre_pin,
    input wire logic mr5_wr,
    input wire logic [15:0] mr5_wdata,
    // outputs
    input wire logic exec_valid,
    input wire logic enter_pd,
    input wire logic prech_all,
    input wire logic alert_n,
    input wire logic parity_err_status,
    input wire logic crc_err_status,
    input wire logic [CMD_W-1:0] err_log
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic [2:0] lat_q; // programmed latency code
    logic per_q; // persistent mode
    logic [4:0] low_q; // cycles of alert low, saturating
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            lat_q <= 3'h0;
            per_q <= 1'b0;
        end
        else if (mr5_wr)
        begin
            lat_q <= mr5_wdata[2:0];
            per_q <= mr5_wdata[9];
        end
    end
    always_ff @(posedge mclk)
        low_q <= (srst || alert_n) ? 5'h00 : low_q + {4'h0, low_q != 5'h1F};
    // armed check sees a bad command; no test sends two inside one alert
    wire bad = cmd_valid_pin & (^{cmd_bits_pin, cmd_parity_bit}) & alert_n
        & (lat_q != 3'h0) & (~parity_err_status | per_q);
    property p_on; bad |-> ##[3:4] !alert_n; endproperty
    a_on: assert property (p_on) else $error("alert late");
    property p_st; $fell(alert_n) |-> parity_err_status; endproperty
    a_st: assert property (p_st) else $error("status not set");
    property p_log; bad |-> ##3 (err_log == $past(cmd_bits_pin, 3)); endproperty
    a_log: assert property (p_log) else $error("log wrong");
    property p_crc; $fell(alert_n) |-> !crc_err_status; endproperty
    a_crc: assert property (p_crc) else $error("crc status kept");
    property p_pre; $fell(alert_n) |-> ##[1:8] prech_all; endproperty
    a_pre: assert property (p_pre) else $error("no precharge");
    property p_pw; $fell(alert_n) |=> !alert_n [*7]; endproperty
    a_pw: assert property (p_pw) else $error("alert too short");
    // flag delay and hold cycles of the alert must be silent; the drain
    // cycles in between stay open so that in-flight work can leave the pipe
    property p_idle;
        (!alert_n && (low_q == 5'd1 || low_q == 5'd2 || low_q >= 5'd7)) |-> !exec_valid;
    endproperty
    a_idle: assert property (p_idle) else $error("exec in alert");
    // alert comes back before the longest allowed pulse width
    property p_rel; $fell(alert_n) |-> ##[8:16] alert_n; endproperty
    a_rel: assert property (p_rel) else $error("alert too long");
    property p_pd; (bad && cmd_is_sre_pin) |-> ##[3:8] enter_pd; endproperty
    a_pd: assert property (p_pd) else $error("no power-down");
    c_al: cover property ($fell(alert_n));
    c_per: cover property (per_q && $fell(alert_n));
    c_pd: cover property (enter_pd);
endmodule : cape_handler_chk
bind cape_handler cape_handler_chk #(.CMD_W(CMD_W)) i_chk (.*);
